// file: rtl/flm_mode_ctrl.sv
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none

module flm_mode_ctrl
    import flm_pkg::*;
#(
    parameter int unsigned TO_MIN_CYC  = TO_MIN_MS * CLK_KHZ,
    parameter int unsigned TO_STEP_CYC = TO_STEP_MS * CLK_KHZ
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        hardware_enable_pin,
    input  wire logic        flash_trig_pin,
    input  wire logic        torch_trig_pin,
    output logic [7:0]       led1_code,
    output logic [7:0]       led2_code,
    output flm_state_t       led_state
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] step_to(input logic [7:0] c, input logic [7:0] t,
                                           input logic ex);
        logic [7:0] d;
        logic [7:0] s;
        d = (c < t) ? t - c : c - t;
        s = ex ? (c >> 3) + 8'h01 : 8'h01;
        if (s > d) begin
            s = d;
        end
        return (c < t) ? c + s : c - s;
    endfunction : step_to

    function automatic logic [7:0] rd_reg(input flm_regs_t r, input logic [3:0] i);
        unique case (i)
            IDX_MODE: return r.mode_r;
            IDX_FL1:  return r.fl1;
            IDX_FL2:  return r.fl2;
            IDX_TR1:  return r.tr1;
            IDX_TR2:  return r.tr2;
            IDX_CFG7: return r.cfg7;
            IDX_CFG8: return r.cfg8;
            default:  return 8'h00;
        endcase
    endfunction : rd_reg

    flm_regs_t   st_ff;
    flm_regs_t   nxt_st;
    flm_state_t  nst;
    logic        f_rise;
    logic        f_fall;
    logic        t_rise;
    logic        t_fall;
    logic        to_hit;
    logic        in_fl;
    logic        take;
    logic        jump;
    logic        expo;
    logic [7:0]  tgt1;
    logic [7:0]  tgt2;
    logic [15:0] period;
    logic [31:0] to_lim;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nst    = st_ff.state;
        f_rise = st_ff.fs[1] & ~st_ff.fprev;
        f_fall = ~st_ff.fs[1] & st_ff.fprev;
        t_rise = st_ff.ts[1] & ~st_ff.tprev;
        t_fall = ~st_ff.ts[1] & st_ff.tprev;
        in_fl  = (st_ff.state == ST_FLASH) || (st_ff.state == ST_IR);
        to_lim = TO_MIN_CYC + 32'(st_ff.cfg8[3:0]) * TO_STEP_CYC;
        to_hit = 1'b0;
        take   = hsel && hready && htrans[1] && (haddr[31:6] == 26'h0)
                 && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
        jump   = 1'b0;
        expo   = 1'b0;
        tgt1   = 8'h00;
        tgt2   = 8'h00;
        period = 16'h0000;
        if (!hardware_enable_pin) begin
            // Registers fall back and the bus answers with zeros only.
            nxt_st = REGS_RST;
        end else begin
            // Bus: writes land in the data phase, reads are fetched early.
            nxt_st.wr_pend = take && hwrite;
            nxt_st.a_idx   = haddr[5:2];
            nxt_st.rdata   = 32'h0;
            if (take && !hwrite) begin
                if (haddr[5:2] == IDX_STAT) begin
                    nxt_st.rdata = {8'h00, st_ff.cur2, st_ff.cur1, 3'h0,
                                    st_ff.rflash, st_ff.ext, st_ff.state};
                end else begin
                    nxt_st.rdata = {24'h0, rd_reg(st_ff, haddr[5:2])};
                end
            end
            if (st_ff.wr_pend) begin
                unique case (st_ff.a_idx)
                    IDX_MODE: nxt_st.mode_r = hwdata[7:0];
                    IDX_FL1:  nxt_st.fl1    = hwdata[7:0];
                    IDX_FL2:  nxt_st.fl2    = hwdata[7:0];
                    IDX_TR1:  nxt_st.tr1    = hwdata[7:0];
                    IDX_TR2:  nxt_st.tr2    = hwdata[7:0];
                    IDX_CFG7: nxt_st.cfg7   = hwdata[7:0];
                    IDX_CFG8: nxt_st.cfg8   = hwdata[7:0];
                    default:  ;
                endcase
            end

            // Two-flop synchronisers; only the second stage feeds edges.
            nxt_st.fs    = {st_ff.fs[0], flash_trig_pin};
            nxt_st.ts    = {st_ff.ts[0], torch_trig_pin};
            nxt_st.fprev = st_ff.fs[1];
            nxt_st.tprev = st_ff.ts[1];

            to_hit = in_fl && (st_ff.to_cnt >= to_lim - 32'h1);
            nxt_st.to_cnt = in_fl ? st_ff.to_cnt + 32'h1 : 32'h0;

            if (st_ff.state == ST_SHUTDOWN) begin
                nst = ST_STANDBY;
            end else if (to_hit) begin
                // Time-out beats a mode write landing in the same cycle.
                nxt_st.mode_r[MODE_LSB +: 2] = MODE_STBY;
                nst = ST_STANDBY;
            end else begin
                unique case (nxt_st.mode_r[MODE_LSB +: 2])
                    MODE_FLASH: begin
                        nst = ST_FLASH;
                        nxt_st.ext = 1'b0;
                    end
                    MODE_TORCH: begin
                        nst = ST_TORCH;
                        nxt_st.ext = 1'b0;
                    end
                    MODE_IR: begin
                        // Level style always, whatever the style bit says.
                        if (st_ff.state == ST_IR) begin
                            nst = f_fall ? ST_IR_STANDBY : ST_IR;
                        end else if (nxt_st.mode_r[BIT_FEN] && f_rise) begin
                            nst = ST_IR;
                        end else begin
                            nst = ST_IR_STANDBY;
                        end
                        nxt_st.ext = 1'b0;
                    end
                    default: begin
                        if (st_ff.ext && st_ff.state == ST_FLASH) begin
                            if (!nxt_st.mode_r[BIT_EDGE] && f_fall) begin
                                nst = ST_STANDBY;
                                nxt_st.ext = 1'b0;
                            end
                        end else if (st_ff.ext && st_ff.state == ST_TORCH) begin
                            if (t_fall) begin
                                nst = ST_STANDBY;
                                nxt_st.ext = 1'b0;
                            end
                        end else if (nxt_st.mode_r[BIT_FEN] && f_rise) begin
                            nst = ST_FLASH;
                            nxt_st.ext = 1'b1;
                        end else if (nxt_st.mode_r[BIT_TEN] && t_rise
                                     && !(nxt_st.mode_r[BIT_FEN] && st_ff.fs[1])) begin
                            nst = ST_TORCH;
                            nxt_st.ext = 1'b1;
                        end else begin
                            nst = ST_STANDBY;
                            nxt_st.ext = 1'b0;
                        end
                    end
                endcase
            end
            nxt_st.state = nst;

            // Current targets follow the register values after any write.
            if (nst == ST_FLASH || nst == ST_IR) begin
                tgt1 = nxt_st.fl1;
                tgt2 = nxt_st.mode_r[BIT_OVF] ? nxt_st.fl1 : nxt_st.fl2;
            end else if (nst == ST_TORCH) begin
                tgt1 = nxt_st.tr1;
                tgt2 = nxt_st.mode_r[BIT_OVT] ? nxt_st.tr1 : nxt_st.tr2;
            end
            if (nst == ST_FLASH) begin
                nxt_st.rflash = 1'b1;
            end else if (nst == ST_TORCH) begin
                nxt_st.rflash = 1'b0;
            end

            // A ramp-down after leaving a mode keeps that mode's ramp.
            if (nxt_st.rflash) begin
                period = FR_STEP_CYC << nxt_st.cfg7[RAMP_LSB +: 3];
            end else if (nxt_st.cfg8[RAMP_LSB +: 3] != 3'h0) begin
                period = TR_STEP_CYC << (nxt_st.cfg8[RAMP_LSB +: 3] - 3'h1);
                expo   = nxt_st.cfg8[BIT_EXP];
            end
            jump = (nst == ST_IR) || (st_ff.state == ST_IR);
            if (jump || period == 16'h0000) begin
                nxt_st.cur1 = tgt1;
                nxt_st.cur2 = tgt2;
                nxt_st.step_cnt = 16'h0000;
            end else if (st_ff.cur1 == tgt1 && st_ff.cur2 == tgt2) begin
                nxt_st.step_cnt = 16'h0000;
            end else if (st_ff.step_cnt >= period - 16'h1) begin
                nxt_st.step_cnt = 16'h0000;
                nxt_st.cur1 = step_to(st_ff.cur1, tgt1, expo);
                nxt_st.cur2 = step_to(st_ff.cur2, tgt2, expo);
            end else begin
                nxt_st.step_cnt = st_ff.step_cnt + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= REGS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.ready;
    assign hresp     = st_ff.resp;
    assign hrdata    = st_ff.rdata;
    assign led1_code = st_ff.cur1;
    assign led2_code = st_ff.cur2;
    assign led_state = st_ff.state;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_off;
        !hardware_enable_pin |=> led1_code == 8'h00 && led2_code == 8'h00
            && led_state == ST_SHUTDOWN && hrdata == 32'h0;
    endproperty
    a_off: assert property (p_off) else $error("enable low did not shut down");

    property p_wake;
        hardware_enable_pin && led_state == ST_SHUTDOWN |=> led_state == ST_STANDBY;
    endproperty
    a_wake: assert property (p_wake) else $error("no standby after enable");

    property p_rampdn;
        led_state == ST_STANDBY ##1 led_state == ST_STANDBY
            |-> led1_code <= $past(led1_code) && led2_code <= $past(led2_code);
    endproperty
    a_rampdn: assert property (p_rampdn) else $error("current rose in standby");

    property p_to;
        to_hit |=> st_ff.mode_r[3:2] == MODE_STBY && led_state == ST_STANDBY;
    endproperty
    a_to: assert property (p_to) else $error("time-out left mode set");

    property p_lvl;
        hardware_enable_pin && !st_ff.wr_pend && st_ff.state == ST_FLASH && st_ff.ext
            && f_fall |=> led_state == (st_ff.mode_r[4] ? ST_FLASH : ST_STANDBY)
            || $past(to_hit);
    endproperty
    a_lvl: assert property (p_lvl) else $error("wrong end of pin flash");

    property p_ir;
        led_state == ST_IR |-> led1_code == st_ff.fl1
            && led2_code == (st_ff.mode_r[5] ? st_ff.fl1 : st_ff.fl2);
    endproperty
    a_ir: assert property (p_ir) else $error("infrared current not full");

    property p_iroff;
        led_state == ST_IR ##1 led_state != ST_IR |-> led1_code == 8'h00;
    endproperty
    a_iroff: assert property (p_iroff) else $error("infrared not cut at once");

    property p_mode;
        st_ff.mode_r[3:2] == MODE_TORCH |-> led_state == ST_TORCH;
    endproperty
    a_mode: assert property (p_mode) else $error("mode 10 not torch");

    property p_pri;
        hardware_enable_pin && !st_ff.wr_pend && led_state == ST_STANDBY
            && st_ff.mode_r[3:0] == 4'h3 && f_rise |=> led_state == ST_FLASH;
    endproperty
    a_pri: assert property (p_pri) else $error("flash trigger lost");

    property p_sync;
        $rose(flash_trig_pin) && hardware_enable_pin ##1 hardware_enable_pin
            |=> f_rise ##1 !f_rise;
    endproperty
    a_sync: assert property (p_sync) else $error("trigger edge not seen once");

    property p_tfall;
        hardware_enable_pin && !st_ff.wr_pend && st_ff.state == ST_TORCH && st_ff.ext
            && t_fall |=> led_state == ST_STANDBY;
    endproperty
    a_tfall: assert property (p_tfall) else $error("torch pin fall ignored");

    // Covers mark the scenarios that the bench is expected to reach.
    c_ext_flash: cover property (led_state == ST_FLASH && st_ff.ext);
    c_exp_torch: cover property (led_state == ST_TORCH && st_ff.cfg8[7] && led1_code > 8'h08);
    c_ir:        cover property (led_state == ST_IR ##1 led_state == ST_IR_STANDBY);
    c_timeout:   cover property (to_hit);
    c_torch:     cover property (led_state == ST_TORCH && led1_code != 8'h00);

endmodule : flm_mode_ctrl

`default_nettype wire

// file: rtl/flm_pkg.sv
package flm_pkg;

    // ------------------------------------------------------------
    // Modes, register indices and fields
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SHUTDOWN, ST_STANDBY, ST_FLASH, ST_TORCH, ST_IR, ST_IR_STANDBY
    } flm_state_t;

    localparam logic [3:0] IDX_MODE = 4'h1;
    localparam logic [3:0] IDX_FL1  = 4'h3;
    localparam logic [3:0] IDX_FL2  = 4'h4;
    localparam logic [3:0] IDX_TR1  = 4'h5;
    localparam logic [3:0] IDX_TR2  = 4'h6;
    localparam logic [3:0] IDX_CFG7 = 4'h7;
    localparam logic [3:0] IDX_CFG8 = 4'h8;
    localparam logic [3:0] IDX_STAT = 4'hC;

    localparam int BIT_FEN  = 0;
    localparam int BIT_TEN  = 1;
    localparam int MODE_LSB = 2;
    localparam int BIT_EDGE = 4;
    localparam int BIT_OVF  = 5;
    localparam int BIT_OVT  = 6;
    localparam int RAMP_LSB = 4;
    localparam int BIT_EXP  = 7;

    localparam logic [1:0] MODE_STBY  = 2'h0;
    localparam logic [1:0] MODE_IR    = 2'h1;
    localparam logic [1:0] MODE_TORCH = 2'h2;
    localparam logic [1:0] MODE_FLASH = 2'h3;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CODE_RST = 8'h00;
    localparam logic [7:0] CFG7_RST = 8'h00;
    localparam logic [7:0] CFG8_RST = 8'h0A;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ    = 10;
    localparam int CLK_KHZ    = 10000;
    localparam int CODE_STEPS = 256;
    localparam int FR_MIN_US  = 512;
    localparam int TR_MIN_MS  = 16;
    localparam int TO_MIN_MS  = 10;
    localparam int TO_STEP_MS = 26;
    localparam logic [15:0] FR_STEP_CYC = 16'(FR_MIN_US * CLK_MHZ / CODE_STEPS);
    localparam logic [15:0] TR_STEP_CYC = 16'(TR_MIN_MS * CLK_KHZ / CODE_STEPS);

    typedef struct packed {
        flm_state_t  state;
        logic        ext;
        logic        rflash;
        logic [7:0]  mode_r;
        logic [7:0]  fl1;
        logic [7:0]  fl2;
        logic [7:0]  tr1;
        logic [7:0]  tr2;
        logic [7:0]  cfg7;
        logic [7:0]  cfg8;
        logic [1:0]  fs;
        logic [1:0]  ts;
        logic        fprev;
        logic        tprev;
        logic [31:0] to_cnt;
        logic [15:0] step_cnt;
        logic [7:0]  cur1;
        logic [7:0]  cur2;
        logic        wr_pend;
        logic [3:0]  a_idx;
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
    } flm_regs_t;

    localparam flm_regs_t REGS_RST = '{state: ST_SHUTDOWN, mode_r: MODE_RST,
        fl1: CODE_RST, fl2: CODE_RST, tr1: CODE_RST, tr2: CODE_RST,
        cfg7: CFG7_RST, cfg8: CFG8_RST, ready: 1'b1, default: '0};

endpackage : flm_pkg

// file: verification/flm_gpio_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// System GPIO lines on the far side of the mode control
// ------------------------------------------------------------
module flm_gpio_model #(
    parameter int WAIT_CYC = 1500
) (
    input  wire logic hclk,
    input  wire logic want_en,
    input  wire logic want_flash,
    input  wire logic want_torch,
    output logic      hardware_enable_pin,
    output logic      flash_trig_pin,
    output logic      torch_trig_pin,
    output logic      host_ok
);
    int en_cnt;

    initial begin
        en_cnt = 0;
        hardware_enable_pin = 1'b0;
        flash_trig_pin = 1'b0;
        torch_trig_pin = 1'b0;
    end

    // Pins move just after the edge, as a GPIO block on the same clock would.
    always @(posedge hclk) begin
        hardware_enable_pin <= want_en;
        flash_trig_pin <= want_flash;
        torch_trig_pin <= want_torch;
        if (!hardware_enable_pin) en_cnt <= 0;
        else if (en_cnt < WAIT_CYC) en_cnt <= en_cnt + 1;
    end

    // The host keeps off the bus until enable has been high long enough.
    assign host_ok = hardware_enable_pin && (en_cnt >= WAIT_CYC);
endmodule : flm_gpio_model

`default_nettype wire

// file: verification/flm_mode_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none

module flm_mode_ctrl_tb;
    import flm_pkg::*;
    localparam int TO_MIN = 40;
    localparam int TO_STEP = 400;
    localparam int LIMIT = 40000;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_n, resp_n;
    logic [31:0] haddr, hwdata, hrdata, rdata_n, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        want_en, want_flash, want_torch, en_pin, fl_pin, tr_pin, host_ok, ovf;
    logic [7:0]  led1_code, led2_code, fl1, fl2, tr1, tr2;
    flm_state_t  led_state;
    int          err_count, samples_checked, cycles;
    logic [3:0]  rst_idx [5] = '{IDX_MODE, IDX_FL1, IDX_CFG7, IDX_CFG8, 4'h9};
    logic [7:0]  rst_val [5] = '{MODE_RST, CODE_RST, CFG7_RST, CFG8_RST, 8'h00};

    flm_mode_ctrl #(.TO_MIN_CYC(TO_MIN), .TO_STEP_CYC(TO_STEP)) i_flm_mode_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .hardware_enable_pin(en_pin), .flash_trig_pin(fl_pin), .torch_trig_pin(tr_pin),
        .led1_code(led1_code), .led2_code(led2_code), .led_state(led_state));

    flm_gpio_model #(.WAIT_CYC(1500)) i_flm_gpio_model (
        .hclk(hclk), .want_en(want_en), .want_flash(want_flash), .want_torch(want_torch),
        .hardware_enable_pin(en_pin), .flash_trig_pin(fl_pin), .torch_trig_pin(tr_pin),
        .host_ok(host_ok));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(negedge hclk) begin
        rdy_n <= hreadyout;
        rdata_n <= hrdata;
        resp_n <= hresp;
    end

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            $display("wrong value at %0t: run took too long", $time);
            tally_and_finish();
        end
    end

    function automatic logic [7:0] exp_ch2(input logic o, input logic [7:0] c1, c2);
        return o ? c1 : c2;
    endfunction : exp_ch2

    function automatic logic [7:0] mv(input logic [1:0] m, input int f, t, e, o, p);
        return {1'b0, p[0], o[0], e[0], m, t[0], f[0]};
    endfunction : mv

    function automatic int to_cyc(input int sel);
        return TO_MIN + sel * TO_STEP;
    endfunction : to_cyc

    // Cycles an exponential torch ramp of the shortest nonzero time needs from zero.
    function automatic int exp_cyc(input int t);
        int c;
        int n;
        c = 0;
        n = 0;
        while (c < t) begin
            c = c + ((((c >> 3) + 1) < (t - c)) ? (c >> 3) + 1 : t - c);
            n++;
        end
        return n * int'(TR_STEP_CYC);
    endfunction : exp_cyc

    task automatic report(input string what);
        err_count++;
        $display("wrong value at %0t: %s", $time, what);
    endtask : report

    task automatic chk_code(input logic [7:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) report($sformatf("%s %h, want %h", what, got, exp));
    endtask : chk_code

    task automatic chk_state(input flm_state_t got, exp);
        samples_checked++;
        if (got !== exp) report($sformatf("state %0d, want %0d", got, exp));
    endtask : chk_state

    task automatic chk_word(input logic [31:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) report($sformatf("%s %h, want %h", what, got, exp));
    endtask : chk_word

    // Waits a bounded number of cycles for the state, and the codes if cc is set.
    task automatic wait_out(input flm_state_t s, input logic cc, input logic [7:0] c1, c2,
                            input int lim);
        int n;
        n = 0;
        #1;
        while ((led_state !== s || (cc && (led1_code !== c1 || led2_code !== c2)))
               && n < lim) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk_state(led_state, s);
        if (cc) chk_code(led1_code, c1, "channel one");
        if (cc) chk_code(led2_code, c2, "channel two");
    endtask : wait_out

    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {26'h0, idx, 2'b00};
        do @(posedge hclk); while (rdy_n !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (rdy_n !== 1'b1);
        rd = rdata_n;
        chk_word({31'h0, resp_n}, 32'h0, "bus response");
        // Step past the edge so that outputs it launched are settled.
        #1;
    endtask : xfer

    task automatic pins(input logic f, t);
        @(posedge hclk);
        want_flash <= f;
        want_torch <= t;
    endtask : pins

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        {hresetn, hsel, hwrite, want_flash, want_torch} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        want_en = 1'b1;
        {err_count, samples_checked, cycles} = '0;
        void'($urandom(57060));
        repeat (4) @(posedge hclk);
        chk_state(led_state, ST_SHUTDOWN);
        hresetn <= 1'b1;
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 8);
        while (host_ok !== 1'b1) @(posedge hclk);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, rst_idx[i], 8'h00);
            chk_word(rd, {24'h0, rst_val[i]}, "reset value");
        end
        fl1 = 8'($urandom_range(15, 4));
        fl2 = 8'($urandom_range(15, 4));
        tr1 = 8'($urandom_range(15, 4));
        tr2 = 8'($urandom_range(15, 4));
        ovf = 1'($urandom_range(1, 0));
        xfer(1'b1, IDX_FL1, fl1);
        xfer(1'b1, IDX_FL2, fl2);
        xfer(1'b1, IDX_TR1, tr1);
        xfer(1'b1, IDX_TR2, tr2);
        xfer(1'b1, IDX_CFG8, 8'h0F);
        // Internal flash ramps up linearly, then override, then software off.
        xfer(1'b1, IDX_MODE, mv(MODE_FLASH, 0, 0, 0, 0, 0));
        chk_word({31'h0, led1_code < fl1}, 32'h1, "flash ramp start");
        wait_out(ST_FLASH, 1'b1, fl1, fl2, 400);
        xfer(1'b1, IDX_MODE, mv(MODE_FLASH, 0, 0, 0, 1, 0));
        wait_out(ST_FLASH, 1'b1, fl1, fl1, 400);
        xfer(1'b1, IDX_MODE, 8'h00);
        chk_word({31'h0, led1_code != 8'h00}, 32'h1, "ramp down");
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 400);
        // Torch with a zero ramp time jumps to its codes.
        xfer(1'b1, IDX_MODE, mv(MODE_TORCH, 0, 0, 0, 0, 1));
        wait_out(ST_TORCH, 1'b1, tr1, tr1, 4);
        xfer(1'b1, IDX_MODE, 8'h00);
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 4);
        // Shortest time-out ends internal flash and clears the mode field.
        xfer(1'b1, IDX_CFG8, 8'h00);
        xfer(1'b1, IDX_MODE, mv(MODE_FLASH, 0, 0, 0, 0, 0));
        wait_out(ST_FLASH, 1'b0, 8'h00, 8'h00, 1);
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, to_cyc(0) + 400);
        xfer(1'b0, IDX_MODE, 8'h00);
        chk_word(rd, 32'h0, "mode after time-out");
        // Pin flash, level style then edge style.
        for (int e = 0; e < 2; e++) begin
            xfer(1'b1, IDX_MODE, mv(MODE_STBY, 1, 0, e[0], 0, 0));
            pins(1'b1, 1'b0);
            wait_out(ST_FLASH, 1'b0, 8'h00, 8'h00, 8);
            repeat (10) @(posedge hclk);
            pins(1'b0, 1'b0);
            repeat (8) @(posedge hclk);
            wait_out(e ? ST_FLASH : ST_STANDBY, 1'b0, 8'h00, 8'h00, 0);
            wait_out(ST_STANDBY, 1'b0, 8'h00, 8'h00, to_cyc(0) + 20);
        end
        // Infrared pulses follow the pin at once, even with edge style set.
        // The boost stage is not modelled, so no pass-mode set-up precedes this.
        xfer(1'b1, IDX_MODE, mv(MODE_IR, 1, 0, 1, ovf, 0));
        // The earlier flash still ramps down under its own timing.
        wait_out(ST_IR_STANDBY, 1'b1, 8'h00, 8'h00, 60);
        pins(1'b1, 1'b0);
        wait_out(ST_IR, 1'b1, fl1, exp_ch2(ovf, fl1, fl2), 6);
        pins(1'b0, 1'b0);
        wait_out(ST_IR_STANDBY, 1'b1, 8'h00, 8'h00, 6);
        pins(1'b1, 1'b0);
        wait_out(ST_IR, 1'b0, 8'h00, 8'h00, 6);
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, to_cyc(0) + 10);
        pins(1'b0, 1'b0);
        // Pin torch, then flash winning a coincident torch edge.
        xfer(1'b1, IDX_MODE, mv(MODE_STBY, 0, 1, 0, 0, 0));
        pins(1'b0, 1'b1);
        wait_out(ST_TORCH, 1'b1, tr1, tr2, 8);
        pins(1'b0, 1'b0);
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 8);
        xfer(1'b1, IDX_MODE, mv(MODE_STBY, 1, 1, 0, 0, 0));
        pins(1'b1, 1'b1);
        wait_out(ST_FLASH, 1'b0, 8'h00, 8'h00, 8);
        pins(1'b0, 1'b0);
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 400);
        pins(1'b0, 1'b1);
        wait_out(ST_TORCH, 1'b1, tr1, tr2, 8);
        // Exponential torch ramp reaches a top code in fewer steps than linear.
        pins(1'b0, 1'b0);
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 8);
        xfer(1'b1, IDX_TR1, 8'h0F);
        xfer(1'b1, IDX_CFG8, 8'h90);
        xfer(1'b1, IDX_MODE, mv(MODE_TORCH, 0, 0, 0, 0, 1));
        wait_out(ST_TORCH, 1'b1, 8'h0F, 8'h0F, exp_cyc(15) + 4);
        // Enable drop cuts current at once and wipes the registers.
        @(posedge hclk);
        want_en <= 1'b0;
        wait_out(ST_SHUTDOWN, 1'b1, 8'h00, 8'h00, 3);
        pins(1'b0, 1'b0);
        xfer(1'b1, IDX_FL1, 8'hAA);
        @(posedge hclk);
        want_en <= 1'b1;
        wait_out(ST_STANDBY, 1'b1, 8'h00, 8'h00, 8);
        while (host_ok !== 1'b1) @(posedge hclk);
        xfer(1'b0, IDX_FL1, 8'h00);
        chk_word(rd, 32'h0, "code after disable");
        xfer(1'b0, IDX_CFG8, 8'h00);
        chk_word(rd, {24'h0, CFG8_RST}, "config after disable");
        tally_and_finish();
    end
endmodule : flm_mode_ctrl_tb

`default_nettype wire
